// ---- mdi_pair_map_and_link_led.sv ----
// Summary of operation
// - Gigabit: lane1 is B for MDI, A crossed
// - 10/100: lane1 receives MDI, transmits crossed
// - Gigabit: lane2 is C for MDI, D crossed
// - Gigabit: lane3 is D for MDI, C crossed
// - 10/100: lanes two and three unused
// - Single style: lamp high down, low up
// - Dual style: 100 steady high, activity toggles at 10 and 1000
`timescale 1ns/1ps
`default_nettype none

module mdi_pair_map_and_link_led
    import lane_map_pkg::*;
(
    // Clock and reset
    input  wire logic                      mclk,
    input  wire logic                      rst,
    // Crossover and link state
    input  wire logic                      crossover_sel,
    input  wire lane_map_pkg::link_state_t link_in,
    // Straps and pin
    input  wire logic                      lamp_style_strap,
    input  wire logic                      status_lamp_b_addr_strap_in,
    output logic                           status_lamp_b_addr_strap_out,
    output logic                           status_lamp_b_addr_strap_oe,
    // Results
    output lane_map_pkg::lane_map_t        lane_map,
    output logic                           phy_address_bit1
);

    // ********************************************************
    // Strap and pin synchroniser
    // ********************************************************
    logic [2:0] pin_sync_r;       // Three-stage pin sampler
    logic [2:0] pin_sync_nxt;     // Next sampler value
    logic       style_sync_r;     // Style strap, third stage
    logic [1:0] style_pipe_r;     // Style strap, stages one and two
    logic [1:0] style_pipe_nxt;   // Next style pipe
    logic       style_nxt;        // Style value, stage three
    logic       pin_level_r;      // Agreed pin level
    logic       pin_level_nxt;    // Next agreed pin level

    // Shift pins; accept a pin change once stages two and three agree, style follows stage three
    always_comb begin
        pin_sync_nxt   = {pin_sync_r[1:0], status_lamp_b_addr_strap_in};
        style_pipe_nxt = {style_pipe_r[0], lamp_style_strap};
        pin_level_nxt  = pin_level_r;
        style_nxt      = style_sync_r;
        if (pin_sync_r[1] == pin_sync_r[2]) begin
            pin_level_nxt = pin_sync_r[2];
        end
        if (style_pipe_r[1] == style_sync_r) begin
            style_nxt = style_pipe_r[1];
        end
    end

    // Register synchroniser stages
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pin_sync_r   <= PIN_SYNC_ZERO;
            style_pipe_r <= SYNC_ZERO;
            style_sync_r <= 1'b0;
            pin_level_r  <= 1'b0;
        end else begin
            pin_sync_r   <= pin_sync_nxt;
            style_pipe_r <= style_pipe_nxt;
            style_sync_r <= style_pipe_r[1];
            pin_level_r  <= pin_level_nxt;
        end
    end

    logic style_r;   // Registered style: 0 single, 1 dual
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            style_r <= 1'b0;
        end else begin
            style_r <= style_nxt;
        end
    end

    // ********************************************************
    // Strap capture state machine
    // ********************************************************
    typedef enum logic [1:0] {
        ST_SAMPLE = 2'b01,   // Pin released, settling
        ST_RUN    = 2'b10    // Pin drives lamp
    } strap_state_t;

    strap_state_t state_r;          // Current state
    strap_state_t state_nxt;        // Next state
    logic [1:0]   settle_r;         // Settle counter
    logic [1:0]   settle_nxt;       // Next settle count
    logic         addr_bit_r;       // Latched address bit
    logic         addr_bit_nxt;     // Next latched bit

    // Wait for sampler to fill, then latch the level once
    always_comb begin
        state_nxt    = state_r;
        settle_nxt   = settle_r;
        addr_bit_nxt = addr_bit_r;
        case (state_r)
            ST_SAMPLE: begin
                settle_nxt = settle_r + 2'h1;
                if (settle_r == SETTLE_LAST) begin
                    // Agreed level as it forms; the registered copy is an edge late
                    addr_bit_nxt = pin_level_nxt;
                    state_nxt    = ST_RUN;
                end
            end
            ST_RUN: begin
                settle_nxt = settle_r;
            end
            default: begin
                state_nxt = ST_SAMPLE;
            end
        endcase
    end

    // Register strap state
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_r    <= ST_SAMPLE;
            settle_r   <= SYNC_ZERO;
            addr_bit_r <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            settle_r   <= settle_nxt;
            addr_bit_r <= addr_bit_nxt;
        end
    end

    // ********************************************************
    // Activity blink timer
    // ********************************************************
    logic [20:0] blink_cnt_r;     // Blink counter
    logic [20:0] blink_cnt_nxt;   // Next count
    logic        blink_r;         // Blink phase
    logic        blink_nxt;       // Next phase

    // Free-running half-period divider
    always_comb begin
        blink_cnt_nxt = blink_cnt_r + 21'h000001;
        blink_nxt     = blink_r;
        if (blink_cnt_r == BLINK_CYC_M1) begin
            blink_cnt_nxt = CNT_ZERO;
            blink_nxt     = ~blink_r;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            blink_cnt_r <= CNT_ZERO;
            blink_r     <= 1'b0;
        end else begin
            blink_cnt_r <= blink_cnt_nxt;
            blink_r     <= blink_nxt;
        end
    end

    // ********************************************************
    // Lamp drive
    // ********************************************************
    logic lamp_nxt;   // Next lamp level
    logic lamp_r;     // Lamp level
    logic oe_nxt;     // Next enable
    logic oe_r;       // Pin enable

    // Choose lamp level from style, link and speed
    always_comb begin
        oe_nxt   = (state_r == ST_RUN);
        lamp_nxt = LAMP_OFF;
        if (!link_in.up) begin
            lamp_nxt = LAMP_OFF;
        end else if (!style_r) begin
            lamp_nxt = 1'b0;
        end else begin
            case (link_in.speed)
                SPEED_100: lamp_nxt = 1'b1;
                SPEED_1000,
                SPEED_10:  lamp_nxt = link_in.activity ? blink_r : 1'b0;
                default:   lamp_nxt = LAMP_OFF;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            lamp_r <= LAMP_OFF;
            oe_r   <= 1'b0;
        end else begin
            lamp_r <= lamp_nxt;
            oe_r   <= oe_nxt;
        end
    end

    // ********************************************************
    // Lane mapping
    // ********************************************************
    lane_map_t map_nxt;   // Next lane map
    lane_map_t map_r;     // Lane map

    // One crossover select steers every lane at gigabit, lanes 0 and 1 only at 10/100
    always_comb begin
        if (link_in.speed == SPEED_1000) begin
            map_nxt.lane0 = crossover_sel ? PAIR_B : PAIR_A;
            map_nxt.lane1 = crossover_sel ? PAIR_A : PAIR_B;
            map_nxt.lane2 = crossover_sel ? PAIR_D : PAIR_C;
            map_nxt.lane3 = crossover_sel ? PAIR_C : PAIR_D;
        end else begin
            map_nxt.lane0 = crossover_sel ? PAIR_RX : PAIR_TX;
            map_nxt.lane1 = crossover_sel ? PAIR_TX : PAIR_RX;
            map_nxt.lane2 = PAIR_NONE;
            map_nxt.lane3 = PAIR_NONE;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            map_r <= {PAIR_NONE, PAIR_NONE, PAIR_NONE, PAIR_NONE};
        end else begin
            map_r <= map_nxt;
        end
    end

    // ********************************************************
    // Outputs
    // ********************************************************
    assign lane_map                     = map_r;
    assign phy_address_bit1             = addr_bit_r;
    assign status_lamp_b_addr_strap_out = lamp_r;
    assign status_lamp_b_addr_strap_oe  = oe_r;

endmodule : mdi_pair_map_and_link_led

`default_nettype wire

// ---- lane_map_pkg.sv ----
package lane_map_pkg;

    // ********************************************************
    // Speed modes
    // ********************************************************
    typedef enum logic [1:0] {
        SPEED_10   = 2'h0,
        SPEED_100  = 2'h1,
        SPEED_1000 = 2'h2
    } speed_mode_t;

    // ********************************************************
    // Standard pair codes
    // ********************************************************
    localparam logic [2:0] PAIR_A    = 3'h0;   // Pair A
    localparam logic [2:0] PAIR_B    = 3'h1;   // Pair B
    localparam logic [2:0] PAIR_C    = 3'h2;   // Pair C
    localparam logic [2:0] PAIR_D    = 3'h3;   // Pair D
    localparam logic [2:0] PAIR_TX   = 3'h4;   // 10/100 transmit pair
    localparam logic [2:0] PAIR_RX   = 3'h5;   // 10/100 receive pair
    localparam logic [2:0] PAIR_NONE = 3'h6;   // Lane unused

    // Lane assignment, one code per media lane
    typedef struct packed {
        logic [2:0] lane3;
        logic [2:0] lane2;
        logic [2:0] lane1;
        logic [2:0] lane0;
    } lane_map_t;

    // Link status as seen by the lamp logic
    typedef struct packed {
        logic        up;
        speed_mode_t speed;
        logic        activity;
    } link_state_t;

    // ********************************************************
    // Timing and reset constants
    // ********************************************************
    localparam int          CLK_HZ        = 20000000;   // Clock rate
    localparam int          BLINK_MS      = 50;         // Half period of activity blink
    localparam int          BLINK_CYC     = CLK_HZ / 1000 * BLINK_MS;
    localparam logic [20:0] BLINK_CYC_M1  = 21'(BLINK_CYC - 1);
    localparam logic [20:0] CNT_ZERO      = 21'h000000;
    localparam logic [1:0]  SYNC_ZERO     = 2'h0;
    localparam logic [2:0]  PIN_SYNC_ZERO = 3'h0;       // Pin sampler reset value
    localparam logic [1:0]  SETTLE_LAST   = 2'h3;       // Last settle count before latch
    localparam logic        LAMP_OFF      = 1'b1;       // High means lamp off

endpackage : lane_map_pkg

// ---- lane_map_chk_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module lane_map_chk
    import lane_map_pkg::*;
(
    // Clock and reset
    input wire logic                      mclk,
    input wire logic                      rst,
    // Watched ports
    input wire logic                      crossover_sel,
    input wire lane_map_pkg::link_state_t link_in,
    input wire logic                      lamp_style_strap,
    input wire logic                      status_lamp_b_addr_strap_in,
    input wire logic                      status_lamp_b_addr_strap_out,
    input wire logic                      status_lamp_b_addr_strap_oe,
    input wire lane_map_pkg::lane_map_t   lane_map,
    input wire logic                      phy_address_bit1
);
    // ****
    // Speed decode
    // ****
    wire logic gig  = link_in.speed == SPEED_1000;
    wire logic slow = link_in.speed == SPEED_10 || link_in.speed == SPEED_100;
    wire logic oe   = status_lamp_b_addr_strap_oe;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    property p_lane1_gig; !rst && gig |=>
        lane_map.lane1 == ($past(crossover_sel) ? PAIR_A : PAIR_B);
    endproperty
    a_lane1_gig: assert property (p_lane1_gig) else $error("lane1 gigabit map");
    property p_lane1_slow; !rst && slow |=>
        lane_map.lane1 == ($past(crossover_sel) ? PAIR_TX : PAIR_RX);
    endproperty
    a_lane1_slow: assert property (p_lane1_slow) else $error("lane1 slow map");
    property p_lane2; !rst && gig |=> lane_map.lane2 == ($past(crossover_sel) ? PAIR_D : PAIR_C);
    endproperty
    a_lane2: assert property (p_lane2) else $error("lane2 gigabit map");
    property p_lane3; !rst && gig |=> lane_map.lane3 == ($past(crossover_sel) ? PAIR_C : PAIR_D);
    endproperty
    a_lane3: assert property (p_lane3) else $error("lane3 gigabit map");
    property p_unused; slow |=> lane_map.lane2 == PAIR_NONE && lane_map.lane3 == PAIR_NONE;
    endproperty
    a_unused: assert property (p_unused) else $error("upper lanes in use");
    property p_addr_latch; $rose(oe) |-> phy_address_bit1 == $past(status_lamp_b_addr_strap_in, 2);
    endproperty
    a_addr_latch: assert property (p_addr_latch) else $error("address bit wrong");
    property p_addr_hold; oe |=> $stable(phy_address_bit1); endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address bit moved");
    property p_rst; disable iff (1'b0) rst |-> !oe && lane_map.lane0 == PAIR_NONE; endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    property p_single; (oe && !lamp_style_strap) [*5] |=>
        status_lamp_b_addr_strap_out == !$past(link_in.up); endproperty
    a_single: assert property (p_single) else $error("single lamp wrong");
    property p_dual_off; (oe && lamp_style_strap) [*5] ##0
        (!link_in.up || link_in.speed == SPEED_100) |=> status_lamp_b_addr_strap_out; endproperty
    a_dual_off: assert property (p_dual_off) else $error("dual lamp not high");
    c_cross: cover property (gig && crossover_sel);
    c_latch: cover property ($rose(oe));
    c_dual: cover property (oe && lamp_style_strap && link_in.up);
endmodule : lane_map_chk
bind mdi_pair_map_and_link_led lane_map_chk i_chk (.mclk, .rst, .crossover_sel, .link_in,
    .lamp_style_strap, .status_lamp_b_addr_strap_in, .status_lamp_b_addr_strap_out,
    .status_lamp_b_addr_strap_oe, .lane_map, .phy_address_bit1);
`default_nettype wire

// ---- lamp_pin_partner.sv ----
`timescale 1ns/1ps
`default_nettype none
module lamp_pin_partner (
    // Device side of the pin
    input  wire logic lamp_out,
    input  wire logic lamp_oe,
    // Board strap resistor level
    input  wire logic strap_level,
    output logic      pin_level
);
    // Resistor sets the pin while the device lets go
    assign pin_level = lamp_oe ? lamp_out : strap_level;
endmodule : lamp_pin_partner
`default_nettype wire

// ---- mdi_pair_map_and_link_led_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module mdi_pair_map_and_link_led_test;
    import lane_map_pkg::*;
    logic        mclk = 1'b0, rst = 1'b0, xsel = 1'b0, dual = 1'b0, strap = 1'b0;
    link_state_t link_in = '0;
    lane_map_t   lane_map;
    logic        pin, lamp_out, lamp_oe, addr1;
    int          err_count = 0, samples_checked = 0;
    always #25 mclk = ~mclk;
    mdi_pair_map_and_link_led i_dut (.mclk(mclk), .rst(rst), .crossover_sel(xsel),
        .link_in(link_in), .lamp_style_strap(dual), .status_lamp_b_addr_strap_in(pin),
        .status_lamp_b_addr_strap_out(lamp_out), .status_lamp_b_addr_strap_oe(lamp_oe),
        .lane_map(lane_map), .phy_address_bit1(addr1));
    lamp_pin_partner i_pin (.lamp_out(lamp_out), .lamp_oe(lamp_oe), .strap_level(strap),
        .pin_level(pin));
    // ****
    // Expectations
    // ****
    function automatic lane_map_t exp_map(speed_mode_t s, logic x);
        if (s == SPEED_1000) return x ? {PAIR_C, PAIR_D, PAIR_A, PAIR_B}
                                      : {PAIR_D, PAIR_C, PAIR_B, PAIR_A};
        return x ? {PAIR_NONE, PAIR_NONE, PAIR_TX, PAIR_RX} : {PAIR_NONE, PAIR_NONE, PAIR_RX, PAIR_TX};
    endfunction : exp_map
    function automatic logic exp_lamp(logic d, link_state_t l);
        if (!l.up) return 1'b1;
        return d && l.speed == SPEED_100;
    endfunction : exp_lamp
    task automatic check(string name, logic [11:0] seen, logic [11:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic give_verdict;
        $display("checked %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    // Drive a link state, then compare both results
    task automatic apply(logic u, speed_mode_t s, logic a, logic x, logic d);
        @(posedge mclk);
        link_in <= {u, s, a};
        xsel    <= x;
        dual    <= d;
        repeat (6) @(posedge mclk);
        #1;
        check("lane_map", lane_map, exp_map(s, x));
        check("lamp", {11'h000, lamp_out}, {11'h000, exp_lamp(d, {u, s, a})});
    endtask : apply
    // Reset with a strap level, then read the latch
    task automatic do_reset(logic b);
        @(posedge mclk);
        strap <= b;
        rst   <= 1'b1;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        repeat (6) @(posedge mclk);
        #1;
        check("addr", {11'h000, addr1}, {11'h000, b});
        check("oe", {11'h000, lamp_oe}, 12'h001);
        $display("reset strap test done");
    endtask : do_reset
    initial begin
        repeat (100000) @(posedge mclk);
        err_count++;
        give_verdict();
    end
    initial begin
        void'($urandom(32'h4155F7D4));
        do_reset(1'b0);
        for (int s = 0; s < 3; s++) begin
            for (int x = 0; x < 2; x++) begin
                apply(1'b1, speed_mode_t'(s), 1'b0, x[0], 1'b0);
                apply(1'b1, speed_mode_t'(s), 1'b0, x[0], 1'b1);
            end
        end
        apply(1'b0, SPEED_1000, 1'b0, 1'b1, 1'b1);
        $display("fixed map and lamp test done");
        repeat (24) apply(1'($urandom), speed_mode_t'($urandom % 3), 1'($urandom),
                          1'($urandom), 1'b0);
        $display("random test done");
        do_reset(1'b1);
        apply(1'b1, SPEED_10, 1'b0, 1'b0, 1'b0);
        check("addr held", {11'h000, addr1}, 12'h001);
        $display("address hold test done");
        give_verdict();
    end
endmodule : mdi_pair_map_and_link_led_test
`default_nettype wire
